// file: dv/sesc_mem_model.sv
`timescale 1ns/1ps
// behavioural scrubbing memory: function select decode and scrub engine
module sesc_mem_model
	import sesc_pkg::*;
(
	input  wire logic               clk_i,    // model clock
	input  wire logic               rst_i,    // power-up
	input  wire logic               inject_i, // single-bit upset seen by scrubs
	input  sesc_pkg::sesc_mem_out_s pins_i,   // controller pins
	output sesc_pkg::sesc_mem_in_s  pins_o    // device pins
);
	logic [12:0] cfg_q;
	sesc_ptr_t   cnt_q;
	logic [31:0] last_q;
	int          tmr_q;
	logic        sel;
	logic        en;
	logic        warn;
	logic        act;
	int          dly;
	int          per;

	// function select pattern, interval and delay from the fields
	assign sel  = !pins_i.ce_low_n && pins_i.ce_high && pins_i.oe_n && pins_i.we_n
		&& !pins_i.err_oe_n && pins_i.err_o;
	assign en   = !cfg_q[8] && !cfg_q[11];
	assign dly  = 2 + int'(cfg_q[7:4]);
	assign per  = 8 << (cfg_q[3:0] - 4'h4);
	assign warn = en && tmr_q < dly + 11;
	assign act  = en && tmr_q >= dly && tmr_q < dly + 10;

	// pins toward the controller; released data lines toggle each cycle
	// an injected upset is single-bit, always corrected, flagged only in single-bit mode
	always_comb
	begin
		pins_o.scrub_warning_n = !warn;
		pins_o.scrub_active_n  = !act;
		pins_o.error_flag      = !pins_i.err_oe_n ? pins_i.err_o
			: act && inject_i && cfg_q[12];
		pins_o.dq              = ~last_q;
		if (sel && pins_i.addr[9] && !pins_i.addr[10])
			pins_o.dq = {19'h7FFFF, cfg_q};
		if (sel && pins_i.addr[7] && pins_i.addr[10])
			pins_o.dq = {13'h1FFF, cnt_q};
	end

	// config register, scrub pointer and interval timer
	always_ff @(posedge clk_i)
	begin
		last_q <= pins_o.dq;
		if (rst_i)
		begin
			cfg_q  <= 13'h0900;
			cnt_q  <= '0;
			tmr_q  <= 0;
			last_q <= 32'h5A5A5A5A;
		end
		else if (sel && !pins_i.addr[9] && !pins_i.addr[10])
		begin
			cfg_q <= pins_i.addr[12:0];
			cnt_q <= '1;
			tmr_q <= 0;
		end
		else
		begin
			tmr_q <= (tmr_q + 1 >= per) ? 0 : tmr_q + 1;
			if (act && tmr_q == dly + 9)
				cnt_q <= cnt_q + 19'h00001;
		end
	end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import sesc_pkg::*;
	logic          clk_i  = 1'b0;
	logic          rst_i  = 1'b1;
	logic          cyc    = 1'b0;
	logic          stb    = 1'b0;
	logic          we     = 1'b0;
	logic          inject = 1'b0;
	logic [3:0]    adr    = 4'h0;
	logic [31:0]   wdat   = 32'h0;
	logic [31:0]   rdat;
	logic [31:0]   q;
	logic          wb_ack;
	logic          mwait;
	sesc_mem_out_s mo;
	sesc_mem_in_s  mi;
	int            n_fail  = 0;
	int            checked = 0;

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	sesc_ctrl sesc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(wb_ack), .role_select_i(1'b0), .mem_i(mi), .mem_o(mo), .mem_wait_o(mwait));
	sesc_mem_model sesc_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .inject_i(inject),
		.pins_i(mo), .pins_o(mi));

	task final_report;
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic wishbone cycle, read data left in q
	task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	// poll status until bit b reaches v
	task wait_st(input int b, input logic v);
		do wb(4'h8, 1'b0, 32'h0); while (q[b] !== v);
	endtask

	// run one pin function, then fetch the captured data
	task op(input logic [1:0] o);
		wb(4'h0, 1'b1, {29'h0, o, 1'b1});
		wait_st(0, 1'b0);
		wb(4'hC, 1'b0, 32'h0);
	endtask

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(4'h4, 1'b0, 32'h0); chk(q, 32'h000000A7);
		wb(4'h8, 1'b0, 32'h0); chk(q, 32'h0);
		wb(4'h2, 1'b0, 32'h0); chk(q, 32'h0);
		wb(4'h4, 1'b1, 32'h00001E5C);
		op(2'h0);
		op(2'h1); chk(q, 32'h0000185C);
		op(2'h2); chk(q, 32'h0007FFFF);
		// scrubbing on, single-bit reporting, every scrub reports an error
		inject <= 1'b1;
		wb(4'h4, 1'b1, 32'h000010A7);
		op(2'h0);
		wait_st(1, 1'b1); chk({31'h0, mwait}, 32'h1);
		wait_st(2, 1'b1);
		wb(4'h0, 1'b1, 32'h00000005); // refused while scrub active
		wait_st(2, 1'b0);
		wb(4'h8, 1'b0, 32'h0); chk(q & 32'h30, 32'h30);
		inject <= 1'b0;
		op(2'h2); chk(q, 32'h0);
		wb(4'h8, 1'b1, 32'h00000030);
		wb(4'h8, 1'b0, 32'h0); chk(q & 32'h30, 32'h0);
		// correction bypass stops scrubbing
		wb(4'h4, 1'b1, 32'h000001A7);
		op(2'h0);
		repeat (300) @(posedge clk_i);
		op(2'h2); chk(q, 32'h0007FFFF);
		final_report;
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		final_report;
	end
endmodule

// file: verilog/sesc_ctrl.sv
`timescale 1ns/1ps
`include "sesc_params.svh"
// host controller for the scrubbing memory: config, counter read, scrub watch
module sesc_ctrl
	import sesc_pkg::*;
(
	input  wire logic               clk_i,      // 25 MHz clock
	input  wire logic               rst_i,      // sync reset
	input  wire logic [3:0]         wb_adr_i,   // byte address
	input  wire logic [31:0]        wb_dat_i,   // write data
	input  wire logic [3:0]         wb_sel_i,   // byte enables
	input  wire logic               wb_we_i,    // write
	input  wire logic               wb_cyc_i,   // cycle
	input  wire logic               wb_stb_i,   // strobe
	output logic [31:0]             wb_dat_o,   // read data
	output logic                    wb_ack_o,   // ack
	input  wire logic               role_select_i, // strap of attached part
	input  sesc_pkg::sesc_mem_in_s  mem_i,      // memory pins in
	output sesc_pkg::sesc_mem_out_s mem_o,      // memory pins out
	output logic                    mem_wait_o  // access hold for user logic
);
	import sesc_pkg::*;

	sesc_mem_out_s pins_w;
	logic          done_w;
	logic [31:0]   rdat_w;
	logic          start_q, start_d;
	sesc_op_e      op_q, op_d;
	logic [12:0]   cfg_q, cfg_d;
	logic [31:0]   rd_q, rd_d;
	logic          busy_q, busy_d;
	logic          scr_err_q, scr_err_d;
	logic          rej_q, rej_d;
	logic          ack_q, ack_d;
	logic [31:0]   wbd_q, wbd_d;
	logic          wait_q, wait_d;
	logic          scr_q;
	logic          blocked;
	logic          wb_req;

	// memory busy: scrub active low blocks; warning low still allows
	assign blocked = !mem_i.scrub_active_n;
	assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;

	// merges byte lanes into a word
	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	// bus slave and command issue
	always_comb
	begin
		start_d   = 1'b0;
		op_d      = op_q;
		cfg_d     = cfg_q;
		rd_d      = rd_q;
		busy_d    = busy_q;
		scr_err_d = scr_err_q;
		rej_d     = rej_q;
		ack_d     = 1'b0;
		wbd_d     = wbd_q;
		// scrub error caught while scrub active is low, for later pointer read
		if (scr_q && mem_i.error_flag)
			scr_err_d = 1'b1;
		if (done_w)
		begin
			busy_d = 1'b0;
			if (op_q == SESC_OP_CFG_RD)
				rd_d = {19'h0, rdat_w[12:0]};
			else if (op_q == SESC_OP_CNT_RD)
				rd_d = {13'h0, rdat_w[18:0]};
		end
		if (wb_req)
		begin
			ack_d = 1'b1;
			wbd_d = 32'h0000_0000;
			case (wb_adr_i)
				`SESC_REG_CTRL:
				if (wb_we_i && wb_sel_i[0] && wb_dat_i[`SESC_CTRL_GO])
				begin
					if (busy_q || blocked)
						rej_d = 1'b1;
					else
					begin
						op_d    = sesc_op_e'(wb_dat_i[`SESC_CTRL_OP_LO +: 2]);
						start_d = (wb_dat_i[`SESC_CTRL_OP_LO +: 2] != 2'h3);
						busy_d  = start_d;
					end
				end
				`SESC_REG_CFG:
				if (wb_we_i)
					cfg_d = 13'(lanes({19'h0, cfg_q}, wb_dat_i, wb_sel_i));
				else
					wbd_d = {19'h0, cfg_q};
				`SESC_REG_STATUS:
				if (wb_we_i)
				begin
					// write one clears; a new scrub error wins the clear
					if (wb_dat_i[`SESC_ST_SCRERR] && !(scr_q && mem_i.error_flag))
						scr_err_d = 1'b0;
					if (wb_dat_i[`SESC_ST_REJECT])
						rej_d = 1'b0;
				end
				else
					wbd_d = {26'h0, rej_q, scr_err_q, mem_i.error_flag,
						!mem_i.scrub_active_n, !mem_i.scrub_warning_n, busy_q};
				`SESC_REG_RDATA: wbd_d = rd_q;
				default: wbd_d = 32'h0000_0000;
			endcase
		end
	end

	// hold user accesses while warning or scrub pending
	always_comb
		wait_d = !mem_i.scrub_warning_n || !mem_i.scrub_active_n;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_q   <= 1'b0;
			op_q      <= SESC_OP_NONE;
			cfg_q     <= `SESC_CFG_RESET;
			rd_q      <= 32'h0000_0000;
			busy_q    <= 1'b0;
			scr_err_q <= 1'b0;
			rej_q     <= 1'b0;
			ack_q     <= 1'b0;
			wbd_q     <= 32'h0000_0000;
			wait_q    <= 1'b0;
			scr_q     <= 1'b0;
		end
		else
		begin
			start_q   <= start_d;
			op_q      <= op_d;
			cfg_q     <= cfg_d;
			rd_q      <= rd_d;
			busy_q    <= busy_d;
			scr_err_q <= scr_err_d;
			rej_q     <= rej_d;
			ack_q     <= ack_d;
			wbd_q     <= wbd_d;
			wait_q    <= wait_d;
			scr_q     <= !mem_i.scrub_active_n;
		end
	end

	sesc_pins u_pins (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (start_q),
		.op_i    (op_q),
		.cfg_i   (cfg_q),
		.mem_i   (mem_i),
		.mem_o   (pins_w),
		.done_o  (done_w),
		.data_o  (rdat_w)
	);

	assign mem_o      = pins_w;
	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = wbd_q;
	assign mem_wait_o = wait_q;

	// the strap is only informative here; functions need a master part
	logic role_unused;
	assign role_unused = role_select_i;

	sequence s_go;
		start_q;
	endsequence
	sequence s_strobe;
		!mem_o.ce_low_n [*2];
	endsequence

	chk_start_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
		s_go |-> ##1 s_strobe) else $error("pins not strobed after start");
	chk_no_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
		start_q |-> $past(mem_i.scrub_active_n)) else $error("start while scrubbing");
	chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	chk_wait_track: assert property (@(posedge clk_i) disable iff (rst_i)
		!mem_i.scrub_active_n |=> mem_wait_o) else $error("wait not raised");
	chk_cnt_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		(done_w && op_q == SESC_OP_CNT_RD) |=> rd_q[31:19] == 13'h0)
		else $error("upper counter bits kept");
	chk_cfg_rd_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		(done_w && op_q == SESC_OP_CFG_RD) |=> rd_q[31:13] == 19'h0)
		else $error("config read too wide");
	chk_screrr_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(scr_q && mem_i.error_flag) |=> scr_err_q) else $error("scrub error lost");
	chk_busy_done: assert property (@(posedge clk_i) disable iff (rst_i)
		start_q |-> busy_q ##[1:12] !busy_q) else $error("function never completed");
endmodule

// file: verilog/sesc_params.svh
`ifndef SESC_PARAMS_SVH
`define SESC_PARAMS_SVH
// Function
// - controller inserts wait states once scrub warning falls.
// - scrub warning of a slave is left unconnected.
// - master drives scrub active low; slaves take it as an input.
// - while scrub active is low the memory must not be accessed.
// - function select: enables on, output/write enable high, error line high.
// - controller avoids reserved combinations of address bits 7 to 10.
// - after a scrub error the controller may read the pointer counter.
// - counter read returns 19 bits on data 18..0; upper bits ignored.
// - controller writes config and reads it back before relying on it.
// - address bits 18..13 are don't care while programming config.

// wishbone register offsets (byte addresses)
`define SESC_REG_CTRL     4'h0
`define SESC_REG_CFG      4'h4
`define SESC_REG_STATUS   4'h8
`define SESC_REG_RDATA    4'hC
// control register fields
`define SESC_CTRL_GO      0
`define SESC_CTRL_OP_LO   1
// status register fields
`define SESC_ST_BUSY      0
`define SESC_ST_WARN      1
`define SESC_ST_SCRUB     2
`define SESC_ST_ERR       3
`define SESC_ST_SCRERR    4
`define SESC_ST_REJECT    5
// memory address field positions
`define SESC_A_SEL9       9
`define SESC_A_SEL10      10
`define SESC_A_SEL7       7
`define SESC_A_TYPE       12
`define SESC_A_SCRUB_DIS  11
`define SESC_A_BYPASS     8
// recommended config: rate 7, delay 10, all enables 0
`define SESC_CFG_RESET    13'h00A7
`define SESC_CFG_MASK     13'h1FFF
// pin timing in ns
`define SESC_T_CYC_NS     40
`define SESC_T_STROBE_NS  20
`define SESC_T_FLAG_NS    13
`define SESC_STROBE_CYC   ((`SESC_T_STROBE_NS + `SESC_T_CYC_NS - 1) / `SESC_T_CYC_NS)
`define SESC_FLAG_CYC     ((`SESC_T_FLAG_NS + `SESC_T_CYC_NS - 1) / `SESC_T_CYC_NS)
`define SESC_STEP_CYC     (`SESC_STROBE_CYC + `SESC_FLAG_CYC + 1)
`endif

// file: verilog/sesc_pins.sv
`timescale 1ns/1ps
`include "sesc_params.svh"
// drives the function-select pin pattern and holds it for strobe time plus flag time plus one cycle (3 cycles)
module sesc_pins
	import sesc_pkg::*;
(
	input  wire logic              clk_i,    // system clock
	input  wire logic              rst_i,    // sync reset
	input  wire logic              start_i,  // pulse: begin a function
	input  sesc_pkg::sesc_op_e     op_i,     // function to run
	input  wire logic [12:0]       cfg_i,    // config value to program
	input  sesc_pkg::sesc_mem_in_s mem_i,    // sampled pins
	output sesc_pkg::sesc_mem_out_s mem_o,   // driven pins
	output logic                   done_o,   // pulse: function finished
	output logic [31:0]            data_o    // captured read data
);
	import sesc_pkg::*;

	typedef enum logic [1:0] {SP_IDLE, SP_STROBE, SP_RELEASE} sesc_sp_e;

	sesc_sp_e      st_q, st_d;
	logic [3:0]    cnt_q, cnt_d;
	sesc_mem_out_s mem_q, mem_d;
	logic          done_q, done_d;
	logic [31:0]   dat_q, dat_d;

	// address pattern for each function, don't-care bits kept zero
	function automatic logic [18:0] sel_addr(input sesc_op_e op, input logic [12:0] cfg);
		logic [18:0] a;
		a = '0;
		case (op)
			SESC_OP_CFG_WR: a[12:0] = cfg & `SESC_CFG_MASK & ~13'h0600;
			SESC_OP_CFG_RD: a[`SESC_A_SEL9] = 1'b1;
			SESC_OP_CNT_RD:
			begin
				a[`SESC_A_SEL7]  = 1'b1;
				a[`SESC_A_SEL10] = 1'b1;
			end
			default: a = '0;
		endcase
		return a;
	endfunction

	// idle pins: deselected, nothing driven
	function automatic sesc_mem_out_s idle_pins();
		sesc_mem_out_s m;
		m = '0;
		m.ce_low_n = 1'b1;
		m.oe_n     = 1'b1;
		m.we_n     = 1'b1;
		m.err_oe_n = 1'b1;
		m.dq_oe_n  = 1'b1;
		return m;
	endfunction

	// next-state logic
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		mem_d  = mem_q;
		done_d = 1'b0;
		dat_d  = dat_q;
		case (st_q)
			SP_IDLE:
			if (start_i)
			begin
				mem_d          = idle_pins();
				mem_d.ce_low_n = 1'b0;
				mem_d.ce_high  = 1'b1;
				mem_d.err_o    = 1'b1; // error line driven high
				mem_d.err_oe_n = 1'b0;
				mem_d.addr     = sel_addr(op_i, cfg_i);
				cnt_d          = 4'(`SESC_STEP_CYC);
				st_d           = SP_STROBE;
			end
			SP_STROBE:
			if (cnt_q == 4'h1)
			begin
				dat_d = mem_i.dq;
				mem_d = idle_pins();
				st_d  = SP_RELEASE;
			end
			else
				cnt_d = cnt_q - 4'h1;
			SP_RELEASE:
			begin
				done_d = 1'b1;
				st_d   = SP_IDLE;
			end
			default: st_d = SP_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q   <= SP_IDLE;
			cnt_q  <= 4'h0;
			mem_q  <= idle_pins();
			done_q <= 1'b0;
			dat_q  <= 32'h0000_0000;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			mem_q  <= mem_d;
			done_q <= done_d;
			dat_q  <= dat_d;
		end
	end

	assign mem_o  = mem_q;
	assign done_o = done_q;
	assign data_o = dat_q;

	// pins stay in function-select pattern for the first two strobe cycles
	chk_strobe_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(st_q == SP_STROBE) |-> (!mem_q.ce_low_n && mem_q.oe_n && mem_q.we_n
		&& mem_q.err_o) [*2]) else $error("strobe pattern not held");
	chk_no_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == SP_STROBE && mem_q.addr[10]) |-> mem_q.addr[7] && !mem_q.addr[9])
		else $error("reserved select pattern driven");
endmodule

// file: verilog/sesc_pkg.sv
package sesc_pkg;
	typedef enum logic [1:0] {
		SESC_OP_CFG_WR,
		SESC_OP_CFG_RD,
		SESC_OP_CNT_RD,
		SESC_OP_NONE
	} sesc_op_e;

	// memory side pins, controller drives
	typedef struct packed {
		logic        ce_low_n;
		logic        ce_high;
		logic        oe_n;
		logic        we_n;
		logic [18:0] addr;
		logic        err_o;
		logic        err_oe_n;
		logic        dq_oe_n;
	} sesc_mem_out_s;

	// memory side pins, controller samples
	typedef struct packed {
		logic        scrub_warning_n;
		logic        scrub_active_n;
		logic        error_flag;
		logic [31:0] dq;
	} sesc_mem_in_s;

	typedef logic [18:0] sesc_ptr_t;
endpackage
